/* hw/serial_clock_select.sv */
/*
  clock source selection and software clock strobe of a serial unit:
  register port, source selection, clock pin toggle, shift and count.
  assumes a single-cycle register master on clk_i, a timer compare
  pulse on clk_i, and serial pins asynchronous to clk_i.
*/
// Notes on behaviour
// - with an external clock the data output changes on the edge opposite to the sampling edge, through a latch.
// - with software strobe or timer clocking the output latch is transparent and the output changes at once.
// - with source select zero nothing is clocked unless software writes the strobe bit as one, which clocks both.
// - with source select 01 the timer compare event clocks both shift register and counter.
// - with an external source and no strobe selector, shift on rising (low bit 0) or falling (low bit 1) edge, count both.
// - with an external source and the strobe selector set, only toggle-bit writes and software strobe writes clock the counter.
// - with an external source the strobe bit is a stored counter clock selector, not a one-shot.
// - a software strobe shifts once and counts once, the output moving in the same cycle unless an external source was selected before the write.
// - a software strobe shifts in the data input value sampled one cycle earlier.
// - the strobe bit and the toggle bit always read as zero.
// - writing one to the toggle bit inverts the clock pin value whatever the direction bit says.
// - the 4-bit counter advances by exactly one per clock from the selected source.
`timescale 1ns/1ns
module serial_clock_select (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // timer compare match pulse
  input wire logic timer_match_i,
  // serial pins
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_data_input_pin_i,
  // shift and counter side
  output logic shift_clk_o,
  output logic count_clk_o,
  output logic data_out_o,
  output logic [7:0] shift_data_o,
  output logic [3:0] count_value_o
);
  import serial_clk_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    clock_source_t cs;
    logic strobe_sel;
    logic pin_dir;
    logic pin_out;
    logic [7:0] rdata;
    logic shift_clk;
    logic count_clk;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  logic clk_level;
  logic clk_rise;
  logic clk_fall;
  logic di_level;
  logic wr_ctrl;
  logic wr_data;
  logic wr_count;
  logic wr_port;
  logic [1:0] wcs;
  logic sw_strobe;
  logic toggle_wr;
  logic toggle_count;
  logic ext_shift;
  logic ext_count;
  logic timer_clk;
  logic shift_en;
  logic count_en;
  logic latch_load;
  logic transparent;
  logic [7:0] rmux;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pin_sync clk_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_clock_pin_i),
    .level_o(clk_level),
    .rise_o(clk_rise),
    .fall_o(clk_fall)
  );

  pin_sync data_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(serial_data_input_pin_i),
    .level_o(di_level),
    .rise_o(),
    .fall_o()
  );

  //////////////////////////////////////////////////////////////////////
  // clock source selection

  always_comb begin
    wr_ctrl = wr_i && (addr_i == CTRL_OFFSET);
    wr_data = wr_i && (addr_i == DATA_OFFSET);
    wr_count = wr_i && (addr_i == COUNT_OFFSET);
    wr_port = wr_i && (addr_i == PORT_OFFSET);
    wcs = wdata_i[CTRL_CS_LSB +: 2];
    // one-shot strobe only when the written source field selects software mode
    sw_strobe = wr_ctrl && (wcs == CS_SOFTWARE)
      && wdata_i[CTRL_STROBE_BIT];
    toggle_wr = wr_ctrl && wdata_i[CTRL_TOGGLE_BIT];
    toggle_count = toggle_wr && state.cs[1]
      && state.strobe_sel;
    timer_clk = (state.cs == CS_TIMER) && timer_match_i;
    ext_shift = state.cs[1]
      && (state.cs[0] ? clk_fall : clk_rise);
    ext_count = state.cs[1] && !state.strobe_sel
      && (clk_rise || clk_fall);
    shift_en = sw_strobe || timer_clk || ext_shift;
    count_en = sw_strobe || timer_clk || ext_count || toggle_count;
    latch_load = state.cs[1]
      && (state.cs[0] ? clk_rise : clk_fall);
    transparent = !state.cs[1];
  end

  //////////////////////////////////////////////////////////////////////
  // shift register, counter, output latch

  transfer_core core (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .shift_en_i(shift_en),
    .count_en_i(count_en),
    .latch_load_i(latch_load),
    .transparent_i(transparent),
    .data_in_i(di_level),
    .data_wr_i(wr_data),
    .count_wr_i(wr_count),
    .wdata_i(wdata_i),
    .shift_data_o(shift_data_o),
    .count_o(count_value_o),
    .data_out_o(data_out_o)
  );

  //////////////////////////////////////////////////////////////////////
  // registers

  always_comb begin
    rmux = 8'h00;
    unique case (addr_i)
      CTRL_OFFSET: begin
        rmux[CTRL_CS_LSB +: 2] = state.cs;
      end
      DATA_OFFSET: begin
        rmux = shift_data_o;
      end
      COUNT_OFFSET: begin
        rmux[3:0] = count_value_o;
      end
      PORT_OFFSET: begin
        rmux[PORT_DIR_BIT] = state.pin_dir;
        rmux[PORT_OUT_BIT] = state.pin_out;
        rmux[PORT_LEVEL_BIT] = clk_level;
      end
      default: begin
        rmux = 8'h00;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.rdata = rd_i ? rmux : 8'h00;
    next_state.shift_clk = shift_en;
    next_state.count_clk = count_en;
    if (wr_ctrl) begin
      next_state.cs = clock_source_t'(wcs);
      next_state.strobe_sel = wdata_i[CTRL_STROBE_BIT];
    end
    if (wr_port) begin
      next_state.pin_dir = wdata_i[PORT_DIR_BIT];
      next_state.pin_out = wdata_i[PORT_OUT_BIT];
    end
    if (toggle_wr) begin
      next_state.pin_out = ~state.pin_out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state.cs <= clock_source_t'(CS_RESET);
      state.strobe_sel <= STROBE_SEL_RESET;
      state.pin_dir <= PIN_DIR_RESET;
      state.pin_out <= PIN_OUT_RESET;
      state.rdata <= 8'h00;
      state.shift_clk <= 1'b0;
      state.count_clk <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;
  assign serial_clock_pin_o = state.pin_out;
  assign serial_clock_pin_oe_o = state.pin_dir;
  assign shift_clk_o = state.shift_clk;
  assign count_clk_o = state.count_clk;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_strobe_write;
    wr_i && (addr_i == CTRL_OFFSET) && (wdata_i[3:2] == 2'h0)
      && wdata_i[1];
  endsequence

  sequence s_both_clocks;
    shift_clk_o && count_clk_o;
  endsequence

  sequence s_ext_pos_rise;
    (state.cs == CS_EXT_POS) && clk_rise && !wr_i;
  endsequence

  AST_STROBE_CLOCKS: assert property (
    s_strobe_write |=> s_both_clocks
  ) else $error("strobe write did not clock shift and count");

  AST_IDLE_NO_CLOCK: assert property (
    (state.cs == CS_SOFTWARE) && !wr_i |=> !shift_clk_o && !count_clk_o
  ) else $error("clock seen with no source selected");

  AST_TIMER_CLOCKS: assert property (
    (state.cs == CS_TIMER) && timer_match_i |=> s_both_clocks
  ) else $error("timer match did not clock shift and count");

  AST_EXT_SHIFT_EDGE: assert property (
    (state.cs == CS_EXT_POS) && !state.strobe_sel && clk_fall && !wr_i
      |=> count_clk_o && !shift_clk_o
  ) else $error("external falling edge shifted in rising mode");

  AST_EXT_RISE_SHIFT: assert property (
    s_ext_pos_rise |=> shift_clk_o
  ) else $error("external rising edge did not shift");

  AST_SELECTOR_GATES: assert property (
    state.cs[1] && state.strobe_sel && (clk_rise || clk_fall) && !wr_i
      |=> !count_clk_o
  ) else $error("pin edge counted while toggle selected");

  AST_TOGGLE_COUNTS: assert property (
    state.cs[1] && state.strobe_sel && wr_i && (addr_i == CTRL_OFFSET)
      && wdata_i[0] |=> count_clk_o
  ) else $error("toggle write did not clock the counter");

  AST_STROBE_DATA: assert property (
    s_strobe_write |=> shift_data_o[0] == $past(di_level)
  ) else $error("strobe shifted in the wrong data sample");

  AST_TRANSPARENT_OUT: assert property (
    shift_clk_o && (state.cs == CS_SOFTWARE || state.cs == CS_TIMER)
      |-> data_out_o == shift_data_o[7]
  ) else $error("output latch not transparent");

  AST_EXT_LATCH_HOLD: assert property (
    s_ext_pos_rise |=> $stable(data_out_o)
  ) else $error("output moved on the sampling edge");

  AST_STROBE_BITS_ZERO: assert property (
    rd_i && (addr_i == CTRL_OFFSET) |=> rdata_o[1:0] == 2'h0
  ) else $error("strobe bits did not read as zero");

  AST_PIN_TOGGLE: assert property (
    wr_i && (addr_i == CTRL_OFFSET) && wdata_i[0]
      |=> serial_clock_pin_o != $past(serial_clock_pin_o)
  ) else $error("toggle write did not invert the clock pin");

  AST_COUNT_STEP: assert property (
    count_clk_o && !$past(wr_count)
      |-> count_value_o == $past(count_value_o) + 4'h1
  ) else $error("counter did not advance by one");

  AST_STROBE_OUT_NOW: assert property (
    s_strobe_write |=> data_out_o == shift_data_o[7]
      && count_value_o != $past(count_value_o)
  ) else $error("strobe did not move output and count together");

endmodule : serial_clock_select

/* pkg/serial_clk_pkg.sv */
/*
  constants for the serial unit clock select and strobe block:
  register offsets, field positions, reset values, clock source codes.
  assumes a byte-wide register port with a small address space.
*/
package serial_clk_pkg;

  // register offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] DATA_OFFSET = 8'h01;
  localparam logic [7:0] COUNT_OFFSET = 8'h02;
  localparam logic [7:0] PORT_OFFSET = 8'h03;

  // control register fields
  localparam int CTRL_CS_LSB = 2;
  localparam int CTRL_STROBE_BIT = 1;
  localparam int CTRL_TOGGLE_BIT = 0;

  // pin register fields
  localparam int PORT_DIR_BIT = 0;
  localparam int PORT_OUT_BIT = 1;
  localparam int PORT_LEVEL_BIT = 2;

  // reset values
  localparam logic [1:0] CS_RESET = 2'h0;
  localparam logic STROBE_SEL_RESET = 1'h0;
  localparam logic PIN_DIR_RESET = 1'h0;
  localparam logic PIN_OUT_RESET = 1'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  // clock source select codes
  typedef enum logic [1:0] {
    CS_SOFTWARE = 2'h0,
    CS_TIMER = 2'h1,
    CS_EXT_POS = 2'h2,
    CS_EXT_NEG = 2'h3
  } clock_source_t;

endpackage : serial_clk_pkg

/* hw/pin_sync.sv */
/*
  two flip-flop synchroniser with edge detection for one pin.
  assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/1ns
module pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pin
  input wire logic pin_i,
  // synchronised level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import serial_clk_pkg::*;

  typedef struct packed {
    logic meta;
    logic level;
    logic prev;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.meta = pin_i;
    next_state.level = state.meta;
    next_state.prev = state.level;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_o = state.level;
  assign rise_o = state.level & ~state.prev;
  assign fall_o = ~state.level & state.prev;

endmodule : pin_sync

/* hw/transfer_core.sv */
/*
  shift register, 4-bit transfer counter and data output latch.
  assumes shift, count and latch enables are one-cycle pulses on clk_i.
*/
`timescale 1ns/1ns
module transfer_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // clock events
  input wire logic shift_en_i,
  input wire logic count_en_i,
  input wire logic latch_load_i,
  input wire logic transparent_i,
  // serial data in, already synchronised
  input wire logic data_in_i,
  // software loads
  input wire logic data_wr_i,
  input wire logic count_wr_i,
  input wire logic [7:0] wdata_i,
  // state
  output logic [7:0] shift_data_o,
  output logic [3:0] count_o,
  output logic data_out_o
);
  import serial_clk_pkg::*;

  typedef struct packed {
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic dout;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;

  always_comb begin
    next_state = state;
    if (data_wr_i) begin
      next_state.shreg = wdata_i;
    end else if (shift_en_i) begin
      next_state.shreg = {state.shreg[6:0], data_in_i};
    end
    if (count_wr_i) begin
      next_state.cnt = wdata_i[3:0];
    end else if (count_en_i) begin
      next_state.cnt = state.cnt + 4'h1;
    end
    if (transparent_i) begin
      next_state.dout = next_state.shreg[7];
    end else if (latch_load_i) begin
      next_state.dout = state.shreg[7];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= {DATA_RESET, COUNT_RESET, 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign shift_data_o = state.shreg;
  assign count_o = state.cnt;
  assign data_out_o = state.dout;

endmodule : transfer_core

/* sim/serial_peer.sv */
/*
  behavioural far-side serial master driving the clock and data lines.
  assumes the bench calls its tasks just after a system clock edge;
  the clock stands low between frames.
*/
`timescale 1ns/1ns
module serial_peer (
  // serial lines
  output logic sclk_o,
  output logic sdata_o
);
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // msb first, 800 ns period, data set well before the sampling edge
  task automatic send(input logic [7:0] bits, input int n);
    #50;
    for (int i = n - 1; i >= 0; i--) begin
      sdata_o = bits[i];
      #200 sclk_o = 1'b1;
      #400 sclk_o = 1'b0;
      #200;
    end
    // released data line shows no stale value
    sdata_o = ~sdata_o;
  endtask : send
  // static data level for clocking from the system side
  task automatic hold(input logic v);
    sdata_o = v;
  endtask : hold
endmodule : serial_peer

/* sim/tb_serial_clock_select.sv */
/*
  self-checking bench for the serial unit clock select block.
  assumes the design files and serial_peer are compiled first.
*/
`timescale 1ns/1ns
module tb_serial_clock_select;
  import serial_clk_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic timer_match_i = 1'b0;
  logic [7:0] rdata_o, shift_data_o, rd_v;
  logic [3:0] count_value_o;
  logic pin_o, pin_oe, shift_clk_o, count_clk_o, data_out_o;
  wire peer_sclk, peer_sdata, sclk_w;
  int n_fail = 0;
  int compares = 0;
  assign sclk_w = pin_oe ? pin_o : peer_sclk;
  always #50 clk_i = ~clk_i;
  serial_clock_select serial_clock_select_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_match_i(timer_match_i), .serial_clock_pin_i(sclk_w),
    .serial_clock_pin_o(pin_o), .serial_clock_pin_oe_o(pin_oe),
    .serial_data_input_pin_i(peer_sdata), .shift_clk_o(shift_clk_o),
    .count_clk_o(count_clk_o), .data_out_o(data_out_o),
    .shift_data_o(shift_data_o), .count_value_o(count_value_o)
  );
  serial_peer serial_peer_inst (.sclk_o(peer_sclk), .sdata_o(peer_sdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask : rd
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a < 5; a++) begin
      rd(8'(a));
      chk("reset read", rd_v, 8'h00);
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_strobe();
    serial_peer_inst.hold(1'b1);
    wr(DATA_OFFSET, 8'h40);
    wr(CTRL_OFFSET, 8'h00);
    chk("idle shift", {7'h0, shift_clk_o}, 8'h00);
    wr(CTRL_OFFSET, 8'h02);
    chk("strobe shift", {7'h0, shift_clk_o}, 8'h01);
    chk("strobe count clk", {7'h0, count_clk_o}, 8'h01);
    chk("strobe data", shift_data_o, 8'h81);
    chk("strobe count", {4'h0, count_value_o}, 8'h01);
    chk("strobe out", {7'h0, data_out_o}, 8'h01);
    @(posedge clk_i);
    #1 chk("strobe pulse end", {7'h0, shift_clk_o}, 8'h00);
    rd(CTRL_OFFSET);
    chk("strobe read", rd_v, 8'h00);
    $display("test strobe done");
  endtask : t_strobe
  task automatic t_timer();
    serial_peer_inst.hold(1'b0);
    wr(COUNT_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h06);
    chk("timer no strobe", {7'h0, count_clk_o}, 8'h00);
    @(posedge clk_i);
    timer_match_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    timer_match_i <= 1'b0;
    #1 chk("timer count", {4'h0, count_value_o}, 8'h03);
    chk("timer data", shift_data_o, 8'h08);
    chk("timer out", {7'h0, data_out_o}, 8'h00);
    $display("test timer done");
  endtask : t_timer
  task automatic t_toggle();
    wr(PORT_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h01);
    chk("toggle pin", {7'h0, pin_o}, 8'h01);
    chk("toggle oe", {7'h0, pin_oe}, 8'h00);
    chk("toggle no count", {4'h0, count_value_o}, 8'h03);
    wr(PORT_OFFSET, 8'h03);
    chk("toggle oe on", {7'h0, pin_oe}, 8'h01);
    wr(CTRL_OFFSET, 8'h01);
    chk("toggle back", {7'h0, pin_o}, 8'h00);
    repeat (3) @(posedge clk_i);
    rd(PORT_OFFSET);
    chk("pin reg", rd_v, 8'h01);
    rd(CTRL_OFFSET);
    chk("toggle read", rd_v, 8'h00);
    wr(PORT_OFFSET, 8'h00);
    $display("test toggle done");
  endtask : t_toggle
  task automatic t_ext();
    for (int m = 0; m < 2; m++) begin
      wr(DATA_OFFSET, 8'h14);
      wr(COUNT_OFFSET, 8'h00);
      wr(CTRL_OFFSET, m ? 8'h0c : 8'h08);
      serial_peer_inst.send(8'h0b, 4);
      repeat (5) @(posedge clk_i);
      #1 chk("ext data", shift_data_o, 8'h4b);
      chk("ext count", {4'h0, count_value_o}, 8'h08);
      chk("ext out", {7'h0, data_out_o}, 8'(m));
    end
    $display("test external done");
  endtask : t_ext
  task automatic t_sel();
    wr(DATA_OFFSET, 8'h00);
    wr(COUNT_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h0a);
    serial_peer_inst.send(8'h03, 2);
    repeat (5) @(posedge clk_i);
    #1 chk("sel data", shift_data_o, 8'h03);
    chk("sel no edge count", {4'h0, count_value_o}, 8'h00);
    wr(CTRL_OFFSET, 8'h0b);
    chk("sel count clk", {7'h0, count_clk_o}, 8'h01);
    chk("sel count", {4'h0, count_value_o}, 8'h01);
    wr(CTRL_OFFSET, 8'h09);
    chk("sel stored", {4'h0, count_value_o}, 8'h02);
    serial_peer_inst.send(8'h01, 1);
    repeat (5) @(posedge clk_i);
    #1 chk("sel cleared", {4'h0, count_value_o}, 8'h04);
    $display("test selector done");
  endtask : t_sel
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_strobe();
    t_timer();
    t_toggle();
    t_ext();
    t_sel();
    end_of_test();
  end
endmodule : tb_serial_clock_select
